// [hdl/preset_output_consts.vh]
// Purpose: Shared constants for the preset output controller.
// Assumes: 25 MHz mclk, byte addresses on an 8-bit register port.
// Notes:   Values are kept in one place; modules use the names only.
`ifndef PRESET_OUTPUT_CONSTS_VH
`define PRESET_OUTPUT_CONSTS_VH

// Timing
`define CLK_PERIOD_NS        40
`define TICK_MS              10
// 10 ms at 40 ns, sized for the 18-bit tick counter
`define TICK_CYCLES          18'h3D090
// Entry timeout in 10 ms ticks (10 s)
`define ENTRY_TIMEOUT_TICKS  10'h3E8

// Timed output range in hundredths of a second
`define TIME_MIN_CS          16'h0001
`define TIME_MAX_CS          16'hEA5F

// Register byte offsets
`define OFS_ASSIGN           8'h00
`define OFS_TERM1            8'h04
`define OFS_TERM2            8'h08
`define OFS_TIMED1           8'h0C
`define OFS_TIMED2           8'h10
`define OFS_PRESET1          8'h14
`define OFS_PRESET2          8'h18
`define OFS_RSEL             8'h1C
`define OFS_DUMMY_A          8'h20
`define OFS_DUMMY_B          8'h24
`define OFS_STATUS           8'h28
`define OFS_DISPLAY_A        8'h2C
`define OFS_DISPLAY_B        8'h30

// Field positions
`define ASSIGN_TRACK_BIT     2
`define TERM_REV_BIT         3

// Output assignment modes
`define ASSIGN_SPLIT         2'h1
`define ASSIGN_ALL_B         2'h2
`define ASSIGN_ALL_A         2'h3

// Termination modes
`define TERM_LATCH           3'h3
`define TERM_LATCH_END       3'h4
`define TERM_TIMED           3'h5
`define TERM_BOUND           3'h6

// Reset selection
`define RSEL_A               2'h1
`define RSEL_B               2'h2
`define RSEL_AB              2'h3

// Dummy zero settings and factors
`define DZ_ONE               3'h1
`define DZ_TWO               3'h2
`define DZ_THREE             3'h3
`define DZ_NONE              3'h4
`define DZ_FACT_ONE          32'sh0000000A
`define DZ_FACT_TWO          32'sh00000064
`define DZ_FACT_THREE        32'sh000003E8

// Reset values
`define RST_ASSIGN           2'h1
`define RST_TERM             3'h3
`define RST_TIMED            16'h0064
`define RST_PRESET           32'h00000000
`define RST_RSEL             2'h3
`define RST_DUMMY            3'h4

`endif

// [hdl/output_timer.v]
// Purpose: Down-counting pulse timer for one timed output.
// Assumes: tick is a one-cycle pulse every 10 ms.
// Notes:   Clear wins over load, load wins over a tick.
module output_timer (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // Control
    input  wire        tick,
    input  wire        load,
    input  wire        clear,
    input  wire [15:0] dur,
    // State
    output reg         running
);

    reg [15:0] remain;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            running <= 1'b0;
            remain  <= 16'h0000;
        end else if (clear) begin
            running <= 1'b0;
            remain  <= 16'h0000;
        end else if (load) begin
            // A retrigger restarts the full duration
            running <= 1'b1;
            remain  <= dur;
        end else if (tick && running) begin
            if (remain == 16'h0001) begin
                running <= 1'b0;
            end
            remain <= remain - 16'h0001;
        end
    end

endmodule // output_timer

// [hdl/preset_output_controller.v]
// Purpose: Two preset outputs of a dual-channel rate indicator.
// Assumes: Rate inputs and update pulses are synchronous to mclk.
// Notes:   Registers over a plain strobe port; read data one cycle later.
//
// Function
// [R01] Assignment 1 splits outputs A/B, 2 puts both on B, 3 both on A.
// [R02] With tracking, a new preset 2 moves preset 1 by the same amount.
// [R03] Tracking is on when assignment is stored with negative sign.
// [R04] With tracking, writing preset 1 sets the offset; preset 2 unchanged.
// [R05] Remote host reads preset 2 before writing it when tracking.
// [R06] Every mode: output returns to reset state on its channel's reset.
// [R07] Negative termination mode inverts the output level, relay included.
// [R08] Mode 3 latches on at or above preset until manual reset begins.
// [R09] Mode 4 latches like mode 3 but releases when manual reset ends.
// [R10] Mode 5 output 1 triggers at or below if shared, else at or above.
// [R11] Timed output turns off after its value elapses; retrigger extends.
// [R12] Mode 5 output 2 triggers at or above preset 2 every update.
// [R13] Mode 6 output is active exactly while value is at or above preset.
// [R14] Timed values hold 0.01 s to 599.99 s, five digits.
// [R15] A running timed pulse is cut short by manual reset.
// [R16] Timed value is ignored unless the output is in mode 5.
// [R17] Zero timed value rejected; entry stays open until it times out.
// [R18] Dummy zero setting 1..3 appends that many zeros; 4 appends none.
// [R19] Dummy zeros shift digits left: one shows as ten, hundred, thousand.
// [R20] Manual reset touches only selected outputs, never rates or timing.
// [R21] Reset selection 1 hits channel A, 2 channel B, 3 both.
// [R22] Comparisons are signed, evaluated on each channel update.
`include "preset_output_consts.vh"

module preset_output_controller #(
    parameter [17:0] TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // Register port
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata,
    // Rate channels
    input  wire [23:0] rate_a,
    input  wire        upd_a,
    input  wire [23:0] rate_b,
    input  wire        upd_b,
    // Manual reset, high while held
    input  wire        man_rst,
    // Load outputs
    output reg         out1,
    output reg         out2
);

    localparam [17:0] TICK_LAST = TICK_CYCLES - 18'h00001;

    // Configuration
    reg [1:0]         assign_mode;
    reg               track;
    reg [2:0]         term1_mode;
    reg               term1_rev;
    reg [2:0]         term2_mode;
    reg               term2_rev;
    reg [15:0]        timed1;
    reg [15:0]        timed2;
    reg signed [31:0] preset1;
    reg signed [31:0] preset2;
    reg [1:0]         rsel;
    reg [2:0]         dummy_a;
    reg [2:0]         dummy_b;

    // Internal state
    reg        [17:0] tick_cnt;
    reg               tick;
    reg        [1:0]  entry_pend;
    reg        [9:0]  entry_cnt;
    reg               man_rst_d;
    reg               act1;
    reg               act2;
    reg        [31:0] next_rdata;

    wire              run1;
    wire              run2;

    // Display value after dummy zeros
    function signed [31:0] scale;
        input [23:0] r;
        input [2:0]  dz;
        reg signed [31:0] ext;
        begin
            ext = $signed({{8{r[23]}}, r});
            case (dz)
                `DZ_ONE:   scale = ext * `DZ_FACT_ONE;   // R18
                `DZ_TWO:   scale = ext * `DZ_FACT_TWO;   // R19
                `DZ_THREE: scale = ext * `DZ_FACT_THREE; // R19
                default:   scale = ext;                  // R18
            endcase
        end
    endfunction

    // Channel of an output: 0 is A, 1 is B
    function out_chan;
        input [1:0] mode;
        input       second;
        begin
            case (mode)
                `ASSIGN_ALL_B: out_chan = 1'b1; // R01
                `ASSIGN_ALL_A: out_chan = 1'b0; // R01
                default:       out_chan = second; // R01
            endcase
        end
    endfunction

    // Does the reset selection cover a channel
    function covers;
        input [1:0] sel;
        input       chan;
        begin
            case (sel)
                `RSEL_A:  covers = ~chan;  // R21
                `RSEL_B:  covers = chan;   // R21
                `RSEL_AB: covers = 1'b1;   // R21
                default:  covers = 1'b0;
            endcase
        end
    endfunction

    // Latched and boundary behaviour, before phase
    function next_act;
        input [2:0] mode;
        input       act;
        input       upd;
        input       cond;
        input       rbeg;
        input       rend;
        begin
            case (mode)
                `TERM_LATCH: begin
                    if (rbeg) begin
                        next_act = 1'b0; // R08
                    end else if (upd && cond) begin
                        next_act = 1'b1; // R08
                    end else begin
                        next_act = act;
                    end
                end
                `TERM_LATCH_END: begin
                    if (rend) begin
                        next_act = 1'b0; // R09
                    end else if (upd && cond) begin
                        next_act = 1'b1; // R09
                    end else begin
                        next_act = act;
                    end
                end
                `TERM_BOUND: begin
                    if (rbeg) begin
                        next_act = 1'b0; // R06
                    end else if (upd) begin
                        next_act = cond; // R13
                    end else begin
                        next_act = act;
                    end
                end
                default: next_act = 1'b0;
            endcase
        end
    endfunction

    // Timed value must be non-zero and within range
    function time_ok;
        input [31:0] v;
        begin
            time_ok = (v[31:16] == 16'h0000) && (v[15:0] >= `TIME_MIN_CS) &&
                      (v[15:0] <= `TIME_MAX_CS); // R14
        end
    endfunction

    wire signed [31:0] disp_a = scale(rate_a, dummy_a);
    wire signed [31:0] disp_b = scale(rate_b, dummy_b);

    wire chan1 = out_chan(assign_mode, 1'b0);
    wire chan2 = out_chan(assign_mode, 1'b1);

    wire               upd1  = chan1 ? upd_b : upd_a;
    wire               upd2  = chan2 ? upd_b : upd_a;
    wire signed [31:0] disp1 = chan1 ? disp_b : disp_a;
    wire signed [31:0] disp2 = chan2 ? disp_b : disp_a;

    // Reset edges per output; rate paths never see the reset
    wire rst_rise = man_rst & ~man_rst_d;
    wire rst_fall = ~man_rst & man_rst_d;
    wire rbeg1    = rst_rise & covers(rsel, chan1); // R20
    wire rend1    = rst_fall & covers(rsel, chan1); // R20
    wire rbeg2    = rst_rise & covers(rsel, chan2); // R20
    wire rend2    = rst_fall & covers(rsel, chan2); // R20

    // Shared channel flips the output 1 comparison in timed mode
    wire shared = (assign_mode != `ASSIGN_SPLIT);
    wire cond1  = (term1_mode == `TERM_TIMED && shared) ?
                  (disp1 <= preset1) : (disp1 >= preset1); // R10 R22
    wire cond2  = (disp2 >= preset2); // R12 R22

    wire timed1_on = (term1_mode == `TERM_TIMED);
    wire timed2_on = (term2_mode == `TERM_TIMED);

    wire load1  = timed1_on & upd1 & cond1; // R10 R11
    wire load2  = timed2_on & upd2 & cond2; // R12 R11
    wire clear1 = rbeg1 | ~timed1_on;       // R15 R16
    wire clear2 = rbeg2 | ~timed2_on;       // R15 R16

    output_timer u_timer1 (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .tick    (tick),
        .load    (load1),
        .clear   (clear1),
        .dur     (timed1),
        .running (run1)
    );

    output_timer u_timer2 (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .tick    (tick),
        .load    (load2),
        .clear   (clear2),
        .dur     (timed2),
        .running (run2)
    );

    // 10 ms tick for timers and entry timeout
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 18'h00000;
            tick     <= 1'b0;
        end else if (tick_cnt == TICK_LAST) begin
            tick_cnt <= 18'h00000;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 18'h00001;
            tick     <= 1'b0;
        end
    end

    // Configuration writes; invalid mode codes are dropped
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            assign_mode <= `RST_ASSIGN;
            track       <= 1'b0;
            term1_mode  <= `RST_TERM;
            term1_rev   <= 1'b0;
            term2_mode  <= `RST_TERM;
            term2_rev   <= 1'b0;
            timed1      <= `RST_TIMED;
            timed2      <= `RST_TIMED;
            preset1     <= `RST_PRESET;
            preset2     <= `RST_PRESET;
            rsel        <= `RST_RSEL;
            dummy_a     <= `RST_DUMMY;
            dummy_b     <= `RST_DUMMY;
        end else if (wr) begin
            case (addr)
                `OFS_ASSIGN: begin
                    if (wdata[1:0] != 2'h0) begin
                        assign_mode <= wdata[1:0];             // R01
                        track       <= wdata[`ASSIGN_TRACK_BIT]; // R03
                    end
                end
                `OFS_TERM1: begin
                    if (wdata[2:0] >= `TERM_LATCH && wdata[2:0] <= `TERM_BOUND) begin
                        term1_mode <= wdata[2:0];
                        term1_rev  <= wdata[`TERM_REV_BIT]; // R07
                    end
                end
                `OFS_TERM2: begin
                    if (wdata[2:0] >= `TERM_LATCH && wdata[2:0] <= `TERM_BOUND) begin
                        term2_mode <= wdata[2:0];
                        term2_rev  <= wdata[`TERM_REV_BIT]; // R07
                    end
                end
                `OFS_TIMED1: begin
                    if (time_ok(wdata)) begin
                        timed1 <= wdata[15:0]; // R14 R17
                    end
                end
                `OFS_TIMED2: begin
                    if (time_ok(wdata)) begin
                        timed2 <= wdata[15:0]; // R14 R17
                    end
                end
                `OFS_PRESET1: begin
                    preset1 <= wdata; // R04
                end
                `OFS_PRESET2: begin
                    preset2 <= wdata;
                    if (track) begin
                        // Offset kept; wraps like the stored values
                        preset1 <= preset1 + ($signed(wdata) - preset2); // R02
                    end
                end
                `OFS_RSEL: begin
                    if (wdata[1:0] != 2'h0) begin
                        rsel <= wdata[1:0]; // R21
                    end
                end
                `OFS_DUMMY_A: begin
                    if (wdata[2:0] >= `DZ_ONE && wdata[2:0] <= `DZ_NONE) begin
                        dummy_a <= wdata[2:0]; // R18
                    end
                end
                `OFS_DUMMY_B: begin
                    if (wdata[2:0] >= `DZ_ONE && wdata[2:0] <= `DZ_NONE) begin
                        dummy_b <= wdata[2:0]; // R18
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Rejected timed entry keeps entry open until a good value or timeout
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            entry_pend <= 2'h0;
            entry_cnt  <= 10'h000;
        end else if (wr && (addr == `OFS_TIMED1 || addr == `OFS_TIMED2)) begin
            if (!time_ok(wdata)) begin
                entry_pend[addr == `OFS_TIMED2] <= 1'b1; // R17
                entry_cnt                       <= `ENTRY_TIMEOUT_TICKS;
            end else begin
                entry_pend[addr == `OFS_TIMED2] <= 1'b0; // R17
            end
        end else if (tick && entry_pend != 2'h0) begin
            if (entry_cnt == 10'h001) begin
                entry_pend <= 2'h0; // R17
            end
            entry_cnt <= entry_cnt - 10'h001;
        end
    end

    // Output state and phase
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            man_rst_d <= 1'b0;
            act1      <= 1'b0;
            act2      <= 1'b0;
            out1      <= 1'b0;
            out2      <= 1'b0;
        end else begin
            man_rst_d <= man_rst;
            act1      <= next_act(term1_mode, act1, upd1, cond1, rbeg1, rend1); // R06
            act2      <= next_act(term2_mode, act2, upd2, cond2, rbeg2, rend2); // R06
            out1      <= (timed1_on ? run1 : act1) ^ term1_rev; // R07 R11
            out2      <= (timed2_on ? run2 : act2) ^ term2_rev; // R07 R11
        end
    end

    // Read mux
    always @* begin
        next_rdata = 32'h00000000;
        case (addr)
            `OFS_ASSIGN:    next_rdata = {29'h00000000, track, assign_mode};
            `OFS_TERM1:     next_rdata = {28'h0000000, term1_rev, term1_mode};
            `OFS_TERM2:     next_rdata = {28'h0000000, term2_rev, term2_mode};
            `OFS_TIMED1:    next_rdata = {16'h0000, timed1};
            `OFS_TIMED2:    next_rdata = {16'h0000, timed2};
            `OFS_PRESET1:   next_rdata = preset1;
            `OFS_PRESET2:   next_rdata = preset2; // R05
            `OFS_RSEL:      next_rdata = {30'h00000000, rsel};
            `OFS_DUMMY_A:   next_rdata = {29'h00000000, dummy_a};
            `OFS_DUMMY_B:   next_rdata = {29'h00000000, dummy_b};
            `OFS_STATUS:    next_rdata = {26'h0000000, entry_pend, run2, run1, out2, out1};
            `OFS_DISPLAY_A: next_rdata = disp_a;
            `OFS_DISPLAY_B: next_rdata = disp_b;
            default:        next_rdata = 32'h00000000;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 32'h00000000;
        end
    end

endmodule // preset_output_controller

// [tb/load_relay.sv]
// Purpose: Relay or load hanging on one controller output.
// Assumes: Contact follows the coil one clock late.
// Notes:   No bounce modelled.
module load_relay (
    // Clock and reset
    input  wire mclk,
    input  wire rst_n,
    // Coil and contact
    input  wire coil,
    output reg  contact
);
    timeunit 1ns;
    timeprecision 1ns;
    // Inversion shows on the contact
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) contact <= 1'b0;
        else contact <= coil;
    end
endmodule // load_relay

// [tb/preset_output_chk.sv]
// Purpose: Port-level checks for the preset output controller.
// Assumes: Shadow mode registers follow accepted writes.
// Notes:   Timer expiry is judged by the bench, not here.
`include "preset_output_consts.vh"
module preset_output_chk #(
    parameter [17:0] TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset
    input wire        mclk,
    input wire        rst_n,
    // Register port
    input wire [7:0]  addr,
    input wire [31:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire [31:0] rdata,
    // Channels, manual reset, outputs
    input wire [23:0] rate_a,
    input wire        upd_a,
    input wire [23:0] rate_b,
    input wire        upd_b,
    input wire        man_rst,
    input wire        out1,
    input wire        out2
);
    timeunit 1ns;
    timeprecision 1ns;
    reg  [1:0] asg;
    reg  [1:0] rsel;
    reg  [3:0] t1;
    reg  [3:0] t2;
    reg        mr_d;
    reg  [2:0] h1;
    reg  [2:0] h2;
    wire       ev   = wr | (man_rst ^ mr_d);
    wire       ch1  = (asg == `ASSIGN_ALL_B) ? upd_b : upd_a;
    wire       ch2  = (asg == `ASSIGN_ALL_A) ? upd_a : upd_b;
    wire       sel1 = (asg == `ASSIGN_ALL_B) ? rsel[1] : rsel[0];
    wire       sel2 = (asg == `ASSIGN_ALL_A) ? rsel[0] : rsel[1];
    wire       tok  = wdata[2:0] >= `TERM_LATCH && wdata[2:0] <= `TERM_BOUND;
    wire       m1   = t1[2:0] != `TERM_LATCH_END;
    wire       m2   = t2[2:0] != `TERM_LATCH_END;
    // Cause history: any change of an output outside timed mode must trace back to one of these
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            asg  <= `ASSIGN_SPLIT;
            rsel <= `RSEL_AB;
            t1   <= {1'b0, `RST_TERM};
            t2   <= {1'b0, `RST_TERM};
            mr_d <= 1'b0;
            h1   <= 3'h0;
            h2   <= 3'h0;
        end else begin
            mr_d <= man_rst;
            h1   <= {h1[1:0], ev | ch1};
            h2   <= {h2[1:0], ev | ch2};
            if (wr && addr == `OFS_ASSIGN && wdata[1:0] != 2'h0) asg <= wdata[1:0];
            if (wr && addr == `OFS_RSEL && wdata[1:0] != 2'h0) rsel <= wdata[1:0];
            if (wr && addr == `OFS_TERM1 && tok) t1 <= wdata[3:0];
            if (wr && addr == `OFS_TERM2 && tok) t2 <= wdata[3:0];
        end
    end
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    out1_cause_a: assert property (
        $changed(out1) && t1[2:0] != `TERM_TIMED |-> h1 != 3'h0)
        else $error("out1 moved without cause");
    out2_cause_a: assert property (
        $changed(out2) && t2[2:0] != `TERM_TIMED |-> h2 != 3'h0)
        else $error("out2 moved without cause");
    out1_clear_a: assert property (
        $rose(man_rst) && sel1 && m1 && !ch1 && !wr |-> ##[1:2] out1 == t1[3])
        else $error("out1 not cleared at reset begin");
    out2_clear_a: assert property (
        $rose(man_rst) && sel2 && m2 && !ch2 && !wr |-> ##[1:2] out2 == t2[3])
        else $error("out2 not cleared at reset begin");
    out1_end_a: assert property (
        $fell(man_rst) && sel1 && t1[2:0] == `TERM_LATCH_END && !ch1 && !wr
        |-> ##[1:2] out1 == t1[3])
        else $error("out1 not released at reset end");
    latch_hold_a: assert property (
        t1[2:0] == `TERM_LATCH && out1 != t1[3] && !man_rst && !$past(man_rst)
        && !wr && !$past(wr) |=> out1 != t1[3])
        else $error("latched out1 dropped");
    rdata_idle_a: assert property (
        !$past(rd) |-> rdata == 32'h0)
        else $error("read data outside its cycle");
    rdata_unmap_a: assert property (
        rd && addr > `OFS_DISPLAY_B |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    term_read_a: assert property (
        rd && addr == `OFS_TERM1 |=> rdata == {28'h0, t1})
        else $error("term1 readback wrong");
endmodule // preset_output_chk
bind preset_output_controller preset_output_chk #(.TICK_CYCLES(TICK_CYCLES))
    preset_output_chk_inst (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rate_a(rate_a), .upd_a(upd_a), .rate_b(rate_b),
    .upd_b(upd_b), .man_rst(man_rst), .out1(out1), .out2(out2));

// [tb/preset_output_controller_tb_top.sv]
// Purpose: Directed tests of the preset output controller.
// Assumes: Ten millisecond tick shortened to four clocks.
// Notes:   Outputs are judged at the relay contacts.
`include "preset_output_consts.vh"
module preset_output_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam [17:0] TK = 18'h00004;
    localparam [87:0] RV = {8'h00, 8'h04, 8'h04, 8'h03, 8'h00, 8'h00,
                            8'h64, 8'h64, 8'h03, 8'h03, 8'h01};
    localparam [127:0] DZ = {32'h1, 32'h3E8, 32'h64, 32'hA};
    reg         mclk    = 1'b0;
    reg         rst_n   = 1'b0;
    reg  [7:0]  addr    = 8'h00;
    reg  [31:0] wdata   = 32'h0;
    reg         wr      = 1'b0;
    reg         rd      = 1'b0;
    reg  [23:0] rate_a  = 24'h0;
    reg  [23:0] rate_b  = 24'h0;
    reg         upd_a   = 1'b0;
    reg         upd_b   = 1'b0;
    reg         man_rst = 1'b0;
    wire [31:0] rdata;
    wire        out1;
    wire        out2;
    wire        k1;
    wire        k2;
    reg  [31:0] v;
    integer     mismatches  = 0;
    integer     check_count = 0;
    integer     i;
    always #20 mclk = ~mclk;
    preset_output_controller #(.TICK_CYCLES(TK)) preset_output_controller_inst (
        .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .rate_a(rate_a), .upd_a(upd_a), .rate_b(rate_b), .upd_b(upd_b),
        .man_rst(man_rst), .out1(out1), .out2(out2));
    load_relay load_relay_inst_1 (.mclk(mclk), .rst_n(rst_n), .coil(out1), .contact(k1));
    load_relay load_relay_inst_2 (.mclk(mclk), .rst_n(rst_n), .coil(out2), .contact(k2));
    task check(input [31:0] seen, input [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wreg(input [7:0] a, input [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask
    task rreg(input [7:0] a);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // Contact lags a clock, hence three edges
    task outs(input [1:0] e);
        repeat (3) @(posedge mclk);
        #1 check({k2, k1}, e);
    endtask
    task upd(input b, input [23:0] r, input [1:0] e);
        if (b) rate_b <= r;
        else rate_a <= r;
        upd_b <= b;
        upd_a <= ~b;
        @(posedge mclk);
        upd_a <= 1'b0;
        upd_b <= 1'b0;
        outs(e);
    endtask
    task mr(input l, input [1:0] e);
        man_rst <= l;
        outs(e);
    endtask
    task hold(input [1:0] e);
        repeat (20) @(posedge mclk);
        outs(e);
    endtask
    task conclude;
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        mismatches = mismatches + 1;
        conclude;
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        for (i = 0; i < 11; i = i + 1) begin
            rreg((i == 10) ? 8'h34 : i * 4);
            check(v, RV[8 * i +: 8]);
        end
        rate_a <= 24'h1;
        rate_b <= 24'h1;
        for (i = 1; i < 5; i = i + 1) begin
            wreg(`OFS_DUMMY_A, i);
            wreg(`OFS_DUMMY_B, i);
            rreg(`OFS_DISPLAY_A);
            check(v, DZ[32 * i - 32 +: 32]);
            rreg(`OFS_DISPLAY_B);
            check(v, DZ[32 * i - 32 +: 32]);
        end
        wreg(`OFS_ASSIGN, 32'h5);
        wreg(`OFS_PRESET2, 32'hC8);
        wreg(`OFS_PRESET1, 32'h64);
        rreg(`OFS_PRESET2);
        wreg(`OFS_PRESET2, 32'h12C);
        rreg(`OFS_PRESET1);
        check(v, 32'hC8);
        wreg(`OFS_PRESET1, 32'h96);
        rreg(`OFS_PRESET2);
        check(v, 32'h12C);
        wreg(`OFS_ASSIGN, 32'h1);
        wreg(`OFS_PRESET2, 32'h190);
        rreg(`OFS_PRESET1);
        check(v, 32'h96);
        wreg(`OFS_PRESET1, 32'h32);
        wreg(`OFS_PRESET2, 32'h32);
        wreg(`OFS_TERM1, 32'h6);
        wreg(`OFS_TERM2, 32'h6);
        upd(1'b0, 24'h32, 2'b01);
        upd(1'b1, 24'h31, 2'b01);
        upd(1'b0, 24'h31, 2'b00);
        upd(1'b1, 24'h3C, 2'b10);
        wreg(`OFS_PRESET1, 32'hFFFFFFFD);
        upd(1'b0, 24'hFFFFFB, 2'b10);
        upd(1'b0, 24'hFFFFFE, 2'b11);
        wreg(`OFS_TERM1, 32'hE);
        outs(2'b10);
        wreg(`OFS_TERM1, 32'h6);
        wreg(`OFS_ASSIGN, 32'h3);
        upd(1'b0, 24'h3C, 2'b11);
        upd(1'b1, 24'h0, 2'b11);
        wreg(`OFS_ASSIGN, 32'h2);
        upd(1'b1, 24'h0, 2'b01);
        wreg(`OFS_ASSIGN, 32'h1);
        wreg(`OFS_TERM1, 32'h3);
        wreg(`OFS_PRESET1, 32'h32);
        upd(1'b0, 24'h3C, 2'b01);
        upd(1'b0, 24'hA, 2'b01);
        wreg(`OFS_RSEL, 32'h2);
        mr(1'b1, 2'b01);
        mr(1'b0, 2'b01);
        wreg(`OFS_RSEL, 32'h1);
        mr(1'b1, 2'b00);
        mr(1'b0, 2'b00);
        wreg(`OFS_TERM1, 32'h4);
        upd(1'b0, 24'h3C, 2'b01);
        mr(1'b1, 2'b01);
        mr(1'b0, 2'b00);
        wreg(`OFS_TIMED1, 32'h0);
        rreg(`OFS_TIMED1);
        check(v, `RST_TIMED);
        rreg(`OFS_STATUS);
        check(v[4], 1'b1);
        wreg(`OFS_TIMED1, 32'h3);
        rreg(`OFS_STATUS);
        check(v[4], 1'b0);
        wreg(`OFS_TIMED2, 32'hEA5F);
        wreg(`OFS_TIMED2, 32'hEA60);
        rreg(`OFS_TIMED2);
        check(v, 32'hEA5F);
        wreg(`OFS_TIMED2, 32'h2);
        wreg(`OFS_TERM1, 32'h5);
        upd(1'b0, 24'h3C, 2'b01);
        hold(2'b00);
        wreg(`OFS_ASSIGN, 32'h3);
        upd(1'b0, 24'h28, 2'b01);
        hold(2'b00);
        upd(1'b0, 24'h3C, 2'b10);
        upd(1'b0, 24'h0, 2'b01);
        hold(2'b00);
        wreg(`OFS_ASSIGN, 32'h1);
        wreg(`OFS_TERM2, 32'h5);
        for (i = 0; i < 6; i = i + 1) begin
            upd(1'b1, 24'h3C, 2'b10);
        end
        hold(2'b00);
        wreg(`OFS_RSEL, 32'h3);
        upd(1'b1, 24'h3C, 2'b10);
        mr(1'b1, 2'b00);
        mr(1'b0, 2'b00);
        wreg(`OFS_TERM1, 32'h6);
        wreg(`OFS_TIMED1, 32'h1);
        upd(1'b0, 24'h3C, 2'b01);
        hold(2'b01);
        conclude;
    end
endmodule // preset_output_controller_tb_top
